// ==== rtl/frl_top.sv ====
// Purpose: ramp-rate limiter for three fan duty outputs
// Assumes: AUTO_DUTYn come from control logic on MCLK
// Notes:   one duty slot is 1/255 of the fan drive period
// How it works
// - channel 1 step select is bits 2:0 of control A
// - channel 3 step select is bits 2:0 of control B
// - channel 2 step select is bits 6:4 of control B
// - codes 0..7 give steps 1,2,3,5,8,12,24,48 slots
// - unslowed full ramp lasts 35 s down to 0.8 s by code
// - a one-slot step ramps 0 to full in about 35 s
// - manual duty writes are ramped the same way
// - channel 1 setup bit 3 slows its ramp by four
// - channel 2 setup bit 3 slows its ramp by four
// - channel 3 setup bit 3 slows its ramp by four
// - slowed full ramp lasts 140 s down to 3.2 s
// - ramp keeps climbing while target stays above duty
// - control A bit 3 enables smoothing on channel 1
// - control B bit 7 enables channel 2, bit 3 channel 3
// - each update moves duty one step toward target
// - duty counts in slots, 255 to a full period
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module frl_top
  import frl_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPDATE_CYC
)(
  input  wire logic       MCLK,
  input  wire logic       SRST,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  input  wire logic [7:0] AUTO_DUTY1,
  input  wire logic [7:0] AUTO_DUTY2,
  input  wire logic [7:0] AUTO_DUTY3,
  output var  logic [7:0] DUTY1,
  output var  logic [7:0] DUTY2,
  output var  logic [7:0] DUTY3
);

  // ==========================================================
  // declarations
  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_b_q;
  logic [7:0]  man_q   [3];
  logic [7:0]  ceil_q  [3];
  logic [7:0]  setup_q [3];
  logic [7:0]  auto_in [3];
  logic [7:0]  duty    [3];
  logic [7:0]  tgt     [3];
  logic [7:0]  tgt_eff [3];
  logic [2:0]  sel     [3];
  logic        smooth  [3];
  logic        slow    [3];
  logic        manual  [3];
  logic        upd     [3];
  logic [7:0]  a_duty  [3];
  logic [7:0]  a_ceil  [3];
  logic [7:0]  a_setup [3];
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;

  assign auto_in[0] = AUTO_DUTY1;
  assign auto_in[1] = AUTO_DUTY2;
  assign auto_in[2] = AUTO_DUTY3;
  assign a_duty[0]  = A_DUTY1;
  assign a_duty[1]  = A_DUTY2;
  assign a_duty[2]  = A_DUTY3;
  assign a_ceil[0]  = A_CEIL1;
  assign a_ceil[1]  = A_CEIL2;
  assign a_ceil[2]  = A_CEIL3;
  assign a_setup[0] = A_SETUP1;
  assign a_setup[1] = A_SETUP2;
  assign a_setup[2] = A_SETUP3;

  // ==========================================================
  // shared smoothing control registers
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctrl_a_q <= R_CTRL;
    end else if (WR && ADDR == A_CTRL_A) begin
      ctrl_a_q <= WDATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctrl_b_q <= R_CTRL;
    end else if (WR && ADDR == A_CTRL_B) begin
      ctrl_b_q <= WDATA;
    end
  end

  // ==========================================================
  // per-channel field extraction
  assign smooth[0] = ctrl_a_q[SMOOTH1_BIT];
  assign smooth[1] = ctrl_b_q[SMOOTH2_BIT];
  assign smooth[2] = ctrl_b_q[SMOOTH3_BIT];
  assign sel[0]    = ctrl_a_q[SEL1_LSB +: 3];
  assign sel[1]    = ctrl_b_q[SEL2_LSB +: 3];
  assign sel[2]    = ctrl_b_q[SEL3_LSB +: 3];

  // ==========================================================
  // update timer, one slot step per interval
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick_cnt_q == 32'(UPDATE_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // 255 updates of one slot span the full ramp
  assign tick = (tick_cnt_q == 32'(UPDATE_CYCLES - 1));

  // ==========================================================
  // channels
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ch

      // manual duty, ceiling and setup registers
      always_ff @(posedge MCLK) begin
        if (SRST) begin
          man_q[i] <= R_DUTY;
        end else if (WR && ADDR == a_duty[i]) begin
          man_q[i] <= WDATA;
        end
      end

      always_ff @(posedge MCLK) begin
        if (SRST) begin
          ceil_q[i] <= R_CEIL;
        end else if (WR && ADDR == a_ceil[i]) begin
          ceil_q[i] <= WDATA;
        end
      end

      always_ff @(posedge MCLK) begin
        if (SRST) begin
          setup_q[i] <= R_SETUP;
        end else if (WR && ADDR == a_setup[i]) begin
          setup_q[i] <= WDATA;
        end
      end

      assign slow[i]   = setup_q[i][SLOW_BIT];
      assign manual[i] = (setup_q[i][MODE_LSB +: 3] == MODE_MANUAL);

      // manual target goes through the same limiter
      assign tgt[i]     = manual[i] ? man_q[i] : auto_in[i];
      assign tgt_eff[i] = (tgt[i] > ceil_q[i]) ? ceil_q[i] : tgt[i];

      frl_ramp u_ramp (
        .clk    (MCLK),
        .rst    (SRST),
        .tick   (tick),
        .slow   (slow[i]),
        .en     (smooth[i]),
        .code   (sel[i]),
        .target (tgt_eff[i]),
        .duty_q (duty[i]),
        .upd    (upd[i])
      );

      // ========================================================
      // checks on the ramp
      logic [1:0] ticks_q;
      always_ff @(posedge MCLK) begin
        if (SRST) begin
          ticks_q <= 2'h0;
        end else if (tick) begin
          ticks_q <= ticks_q + 2'h1;
        end
      end

      property p_up;
        @(posedge MCLK) disable iff (SRST)
        smooth[i] && upd[i] && tgt_eff[i] > duty[i]
          && (tgt_eff[i] - duty[i]) >= frl_step(sel[i])
          |=> duty[i] == 8'($past(duty[i]) + frl_step($past(sel[i])));
      endproperty
      step_up_a: assert property (p_up)
        else $error("duty did not rise by one step");

      step_down_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        smooth[i] && upd[i] && tgt_eff[i] < duty[i]
          && (duty[i] - tgt_eff[i]) >= frl_step(sel[i])
          |=> duty[i] == 8'($past(duty[i]) - frl_step($past(sel[i]))))
        else $error("duty did not fall by one step");

      snap_target_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        smooth[i] && upd[i] && tgt_eff[i] > duty[i]
          && (tgt_eff[i] - duty[i]) < frl_step(sel[i])
          |=> duty[i] == $past(tgt_eff[i]))
        else $error("duty overshot or missed target");

      hold_between_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        smooth[i] && $past(smooth[i]) && !$past(upd[i])
          |-> duty[i] == $past(duty[i]))
        else $error("duty moved without an update");

      bypass_follow_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        !smooth[i] |=> duty[i] == $past(tgt_eff[i]))
        else $error("duty not following target when off");

      slow_quarter_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        slow[i] && tick |-> upd[i] == (ticks_q == 2'h3))
        else $error("slowed channel updated off the fourth tick");

      upd_on_tick_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        upd[i] |-> tick)
        else $error("update outside timer tick");

      keep_climbing_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        smooth[i] && upd[i] && tgt_eff[i] > duty[i]
          |=> duty[i] > $past(duty[i]))
        else $error("ramp-up interrupted");

      snap_down_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        smooth[i] && upd[i] && tgt_eff[i] < duty[i]
          && (duty[i] - tgt_eff[i]) < frl_step(sel[i])
          |=> duty[i] == $past(tgt_eff[i]))
        else $error("duty undershot or missed target");

      ceil_clamp_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        !smooth[i] |=> duty[i] <= $past(ceil_q[i]))
        else $error("duty above ceiling");

      rd_duty_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        RD && ADDR == a_duty[i] |=> RDATA == $past(duty[i]))
        else $error("read data not the channel duty");

      rd_setup_a: assert property (
        @(posedge MCLK) disable iff (SRST)
        RD && ADDR == a_setup[i] |=> RDATA == $past(setup_q[i]))
        else $error("read data not the channel setup");

      ramp_up_c: cover property (
        @(posedge MCLK) disable iff (SRST)
        smooth[i] && upd[i] && tgt_eff[i] > duty[i]);

      ramp_down_c: cover property (
        @(posedge MCLK) disable iff (SRST)
        smooth[i] && upd[i] && tgt_eff[i] < duty[i]);

      slow_upd_c: cover property (
        @(posedge MCLK) disable iff (SRST)
        slow[i] && upd[i] && smooth[i]);

      manual_ramp_c: cover property (
        @(posedge MCLK) disable iff (SRST)
        manual[i] && smooth[i] && upd[i] && duty[i] != man_q[i]);

    end
  endgenerate

  // ==========================================================
  // timer checks
  tick_spacing_a: assert property (
    @(posedge MCLK) disable iff (SRST)
    tick |=> tick_cnt_q == 32'h0000_0000)
    else $error("timer did not restart after tick");

  // ==========================================================
  // read path, data in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    case (ADDR)
      A_DUTY1:  rdata_d = duty[0];
      A_DUTY2:  rdata_d = duty[1];
      A_DUTY3:  rdata_d = duty[2];
      A_CEIL1:  rdata_d = ceil_q[0];
      A_CEIL2:  rdata_d = ceil_q[1];
      A_CEIL3:  rdata_d = ceil_q[2];
      A_SETUP1: rdata_d = setup_q[0];
      A_SETUP2: rdata_d = setup_q[1];
      A_SETUP3: rdata_d = setup_q[2];
      A_CTRL_A: rdata_d = ctrl_a_q;
      A_CTRL_B: rdata_d = ctrl_b_q;
      default:  rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rdata_q <= 8'h00;
    end else if (RD) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign RDATA = rdata_q;
  assign DUTY1 = duty[0];
  assign DUTY2 = duty[1];
  assign DUTY3 = duty[2];

  rd_data_a: assert property (
    @(posedge MCLK) disable iff (SRST)
    RD && ADDR == A_DUTY1 |=> RDATA == $past(duty[0]))
    else $error("read data not the applied duty");

  rd_quiet_a: assert property (
    @(posedge MCLK) disable iff (SRST)
    !RD |=> RDATA == 8'h00)
    else $error("read data outside read cycle");

  wr_ctrl_a: assert property (
    @(posedge MCLK) disable iff (SRST)
    WR && ADDR == A_CTRL_A |=> ctrl_a_q == $past(WDATA))
    else $error("control A write lost");

  wr_ctrl_b_a: assert property (
    @(posedge MCLK) disable iff (SRST)
    WR && ADDR == A_CTRL_B |=> ctrl_b_q == $past(WDATA))
    else $error("control B write lost");

  rd_ctrl_a: assert property (
    @(posedge MCLK) disable iff (SRST)
    RD && ADDR == A_CTRL_B |=> RDATA == $past(ctrl_b_q))
    else $error("read data not control B");

  rd_ctrl_c: cover property (
    @(posedge MCLK) disable iff (SRST)
    WR && ADDR == A_CTRL_B ##1 RD && ADDR == A_CTRL_B);

endmodule
`default_nettype wire

// ==== rtl/frl_pkg.sv ====
// Purpose: shared constants for the fan ramp-rate limiter
// Assumes: 8-bit register port, 40 MHz MCLK
// Notes:   offsets are byte addresses on the register port
package frl_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] A_DUTY1  = 8'h30;
  localparam logic [7:0] A_DUTY2  = 8'h31;
  localparam logic [7:0] A_DUTY3  = 8'h32;
  localparam logic [7:0] A_CEIL1  = 8'h38;
  localparam logic [7:0] A_CEIL2  = 8'h39;
  localparam logic [7:0] A_CEIL3  = 8'h3A;
  localparam logic [7:0] A_SETUP1 = 8'h5C;
  localparam logic [7:0] A_SETUP2 = 8'h5D;
  localparam logic [7:0] A_SETUP3 = 8'h5E;
  localparam logic [7:0] A_CTRL_A = 8'h62;
  localparam logic [7:0] A_CTRL_B = 8'h63;

  // ==========================================================
  // reset values
  localparam logic [7:0] R_DUTY  = 8'h00;
  localparam logic [7:0] R_CEIL  = 8'hFF;
  localparam logic [7:0] R_SETUP = 8'h82;
  localparam logic [7:0] R_CTRL  = 8'h00;

  // ==========================================================
  // field positions
  localparam int         SLOW_BIT    = 3;
  localparam int         MODE_LSB    = 5;
  localparam logic [2:0] MODE_MANUAL = 3'h7;
  localparam int         SMOOTH1_BIT = 3;
  localparam int         SEL1_LSB    = 0;
  localparam int         SMOOTH2_BIT = 7;
  localparam int         SEL2_LSB    = 4;
  localparam int         SMOOTH3_BIT = 3;
  localparam int         SEL3_LSB    = 0;

  // ==========================================================
  // timing
  localparam int SLOTS        = 255;
  localparam int SLOW_FACTOR  = 4;
  localparam int FULL_RAMP_US = 35000000;
  localparam int CLK_MHZ      = 40;
  localparam int UPDATE_US    = FULL_RAMP_US / SLOTS;
  localparam int UPDATE_CYC   = UPDATE_US * CLK_MHZ;

  // ==========================================================
  // step size in time slots per select code
  function automatic logic [7:0] frl_step(input logic [2:0] code);
    logic [7:0] s;
    s = 8'h01;
    case (code)
      3'h0:    s = 8'h01;
      3'h1:    s = 8'h02;
      3'h2:    s = 8'h03;
      3'h3:    s = 8'h05;
      3'h4:    s = 8'h08;
      3'h5:    s = 8'h0C;
      3'h6:    s = 8'h18;
      default: s = 8'h30;
    endcase
    return s;
  endfunction

endpackage

// ==== rtl/frl_ramp.sv ====
// Purpose: one channel of the duty ramp limiter
// Assumes: tick is a one-cycle pulse from the update timer
// Notes:   en low makes the duty follow the target each cycle
`timescale 1ns/100ps
`default_nettype none
module frl_ramp
  import frl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       slow,
  input  wire logic       en,
  input  wire logic [2:0] code,
  input  wire logic [7:0] target,
  output var  logic [7:0] duty_q,
  output var  logic       upd
);

  logic [1:0] div_q;
  logic [7:0] step;
  logic [7:0] gap;
  logic [7:0] duty_d;

  // ==========================================================
  // slowdown divider
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= 2'h0;
    end else if (tick) begin
      div_q <= div_q + 2'h1;
    end
  end

  // quarter of the ticks when slowed
  assign upd = tick && (!slow || div_q == 2'(SLOW_FACTOR - 1));

  // ==========================================================
  // step toward target
  always_comb begin
    step   = frl_step(code);
    gap    = (target > duty_q) ? target - duty_q : duty_q - target;
    duty_d = duty_q;
    if (!en) begin
      duty_d = target;
    end else if (upd && target != duty_q) begin
      if (gap < step) begin
        duty_d = target;
      end else if (target > duty_q) begin
        duty_d = duty_q + step;
      end else begin
        duty_d = duty_q - step;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      duty_q <= R_DUTY;
    end else begin
      duty_q <= duty_d;
    end
  end

endmodule
`default_nettype wire

// ==== bench/frl_fan_model.sv ====
// Purpose: fan drive stage model, measures the duty it is driven with
// Assumes: one duty slot per MCLK cycle
// Notes:   meas holds the high slots seen in the last full period
`timescale 1ns/100ps
`default_nettype none
module frl_fan_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] duty,
  output var  logic [7:0] meas
);
  logic [7:0] slot_q;
  logic [7:0] hi_q;
  logic       drive;

  // ==========================================================
  // period of 255 slots, drive high while slot below duty
  assign drive = (slot_q < duty);
  always @(posedge clk) begin
    if (rst || slot_q == 8'hFE) begin
      slot_q <= 8'h00;
      hi_q   <= 8'h00;
      meas   <= rst ? 8'h00 : hi_q + {7'h00, drive};
    end else begin
      slot_q <= slot_q + 8'h01;
      hi_q   <= hi_q + {7'h00, drive};
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Purpose: self-checking bench of the fan ramp-rate limiter
// Assumes: update timer shortened to 8 cycles
// Notes:   random targets from a fixed-seed xorshift
`timescale 1ns/100ps
`default_nettype none
module tb;
  import frl_pkg::*;
  localparam int UPD = 8;
  localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
  localparam logic [7:0] RA [12] = '{8'h30, 8'h31, 8'h32, 8'h38, 8'h39, 8'h3A, 8'h5C, 8'h5D, 8'h5E,
                                     8'h62, 8'h63, 8'h40};
  localparam logic [7:0] RV [12] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, R_SETUP, R_SETUP,
                                     R_SETUP, 8'h00, 8'h00, 8'h00};
  logic       mclk;
  logic       srst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] auto_t [3];
  wire  logic [7:0] duty [3];
  wire  logic [7:0] meas [3];
  logic [31:0] seed;
  int          error_cnt;
  int          total_checks;
  int          cyc;
  logic [7:0]  v;

  frl_top #(.UPDATE_CYCLES(UPD)) i_dut (
    .MCLK(mclk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .AUTO_DUTY1(auto_t[0]), .AUTO_DUTY2(auto_t[1]), .AUTO_DUTY3(auto_t[2]),
    .DUTY1(duty[0]), .DUTY2(duty[1]), .DUTY3(duty[2])
  );
  for (genvar g = 0; g < 3; g++) begin : g_fan
    frl_fan_model i_fan (.clk(mclk), .rst(srst), .duty(duty[g]), .meas(meas[g]));
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] exp_step(logic [7:0] cur, logic [7:0] tg, logic [7:0] s);
    if (tg > cur) return (tg - cur < s) ? tg : cur + s;
    return (cur - tg < s) ? tg : cur - s;
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus_wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  task automatic bus_rd(logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic set_ctl(int c, logic en, logic [2:0] code);
    if (c == 0) bus_wr(8'h62, {4'h0, en, code});
    else if (c == 1) bus_wr(8'h63, {en, code, 4'h0});
    else bus_wr(8'h63, {4'h0, en, code});
  endtask
  task automatic set_tgt(int c, logic man, logic [7:0] t);
    if (man) bus_wr(8'(8'h30 + c), t);
    else begin
      @(posedge mclk);
      auto_t[c] <= t;
    end
  endtask

  // ==========================================================
  // one ramp from st to tg, every update compared
  task automatic ramp(int c, logic [2:0] code, logic slow, logic man, logic [7:0] st,
                      logic [7:0] tg, logic tweak);
    logic [7:0] cur;
    logic [7:0] d;
    int n;
    int k;
    bus_wr(8'(8'h5C + c), {man ? 3'h7 : 3'h4, 1'b0, slow, 3'h2});
    set_ctl(c, 1'b0, code);
    set_tgt(c, man, st);
    repeat (3) @(posedge mclk);
    #1;
    chk("duty_follow", st, duty[c]);
    set_ctl(c, 1'b1, code);
    set_tgt(c, man, tg);
    cur = st;
    k = 0;
    d = (tg > st) ? tg - st : st - tg;
    while (cur !== tg && k < 300) begin
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n++;
      end while (duty[c] === cur && n < 200);
      chk("duty_step", exp_step(cur, tg, STEPS[code]), duty[c]);
      if (k > 0) chk("step_gap", slow ? 8'(4 * UPD) : 8'(UPD), 8'(n));
      cur = duty[c];
      k++;
      if (tweak && !man && k == 2 && int'(tg) > int'(cur) + 20) begin
        tg = tg - 8'h05;
        auto_t[c] <= tg;
      end
    end
    if (!tweak) chk("update_count", 8'((d + STEPS[code] - 1) / STEPS[code]), 8'(k));
    bus_rd(8'(8'h30 + c), cur);
    chk("duty_readback", tg, cur);
  endtask

  // ==========================================================
  // clock, timeout and main sequence
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    logic [2:0] cd;
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    auto_t = '{default: 8'h00};
    seed = 32'd45;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      bus_rd(RA[i], v);
      chk("reg_reset", RV[i], v);
    end
    for (int c = 0; c < 3; c++) begin
      for (int code = 0; code < 8; code++) begin
        ramp(c, 3'(code), 1'b0, code[0], 8'h00, 8'hFF, 1'b0);
      end
      ramp(c, 3'h7, 1'b1, 1'b0, 8'h00, 8'hFF, 1'b0);
      ramp(c, 3'h4, 1'b1, 1'b1, 8'hFF, 8'(rnd() % 8'hFF), 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      cd = 3'(rnd());
      ramp(int'(rnd() % 3), cd, cd[2], 1'(rnd() % 2), 8'(rnd()), 8'(rnd()), 1'b1);
    end
    for (int c = 0; c < 3; c++) begin
      bus_wr(8'(8'h38 + c), 8'h40);
      bus_wr(8'(8'h5C + c), R_SETUP);
      set_ctl(c, 1'b0, 3'h0);
      set_tgt(c, 1'b0, 8'hC0);
      repeat (520) @(posedge mclk);
      #1;
      chk("duty_ceiling", 8'h40, duty[c]);
      chk("fan_measured", 8'h40, meas[c]);
      bus_rd(8'(8'h38 + c), v);
      chk("ceiling_readback", 8'h40, v);
      bus_wr(8'(8'h38 + c), 8'hFF);
    end
    finish_test();
  end
endmodule
`default_nettype wire
